// >>> rtl/fpucs_pkg.sv
/*
 * fpucs_pkg: constants for the float control/status register block.
 * Assumes a 32-bit APB slave; all files except fpucs_dp_model import this package whole.
 */
package fpucs_pkg;
    // =========================================
    // register offsets
    localparam logic [11:0] FPUCS_CSR_OFF = 12'h000;
    localparam logic [11:0] FPUCS_CC_OFF = 12'h004;
    localparam logic [11:0] FPUCS_EXC_OFF = 12'h008;
    localparam logic [11:0] FPUCS_ENR_OFF = 12'h00C;
    localparam logic [11:0] FPUCS_TRAP_OFF = 12'h010;
    // =========================================
    // field positions
    localparam int FPUCS_CC_HI = 31;
    localparam int FPUCS_CC_LO7 = 25;
    localparam int FPUCS_FS_BIT = 24;
    localparam int FPUCS_CC0_BIT = 23;
    localparam int FPUCS_FO_BIT = 22;
    localparam int FPUCS_FN_BIT = 21;
    localparam int FPUCS_MAC_BIT = 20;
    localparam int FPUCS_ABS_BIT = 19;
    localparam int FPUCS_NAN_BIT = 18;
    localparam int FPUCS_CAUSE_LO = 12;
    localparam int FPUCS_EN_LO = 7;
    localparam int FPUCS_FLAG_LO = 2;
    localparam int FPUCS_RM_LO = 0;
    // =========================================
    // hardwired indicator values and reset values
    localparam logic FPUCS_MAC_VAL = 1'b0;
    localparam logic FPUCS_ABS_VAL = 1'b1;
    localparam logic FPUCS_NAN_VAL = 1'b1;
    localparam logic [7:0] FPUCS_CC_RST = 8'h00;
    localparam logic [5:0] FPUCS_CAUSE_RST = 6'h00;
    localparam logic [4:0] FPUCS_EN_RST = 5'h00;
    localparam logic [4:0] FPUCS_FLAG_RST = 5'h00;
    localparam logic [1:0] FPUCS_RM_RST = 2'h0;
    localparam logic [31:0] FPUCS_ZERO = 32'h0000_0000;
    // =========================================
    // rounding modes
    typedef enum logic [1:0] {
        FPUCS_RM_NEAREST = 2'h0,
        FPUCS_RM_ZERO = 2'h1,
        FPUCS_RM_PINF = 2'h2,
        FPUCS_RM_MINF = 2'h3
    } fpucs_rm_t;
    // tiny result handling, one-hot
    typedef enum logic [3:0] {
        FPUCS_TINY_EXC = 4'h1,
        FPUCS_TINY_FLUSH = 4'h2,
        FPUCS_TINY_NEAR = 4'h4,
        FPUCS_TINY_KEEP = 4'h8
    } fpucs_tiny_t;
endpackage

// >>> rtl/fpucs_tiny.sv
/*
 * fpucs_tiny: decodes the flush controls into the datapath handling mode.
 * Assumes purely combinational use by the top.
 */
`timescale 1ns/1ns
module fpucs_tiny
    import fpucs_pkg::*;
(
    // controls
    input wire logic flush_tiny_enable,
    input wire logic flush_override,
    input wire logic flush_nearest,
    input wire logic [1:0] rounding_select,
    // decoded
    output fpucs_tiny_t mode
);
    // =========================================
    always_comb begin
        if (flush_override) begin
            mode = FPUCS_TINY_KEEP;
        end else if (flush_nearest && rounding_select == FPUCS_RM_NEAREST) begin
            mode = FPUCS_TINY_NEAR;
        end else if (flush_nearest || flush_tiny_enable) begin
            mode = FPUCS_TINY_FLUSH;
        end else begin
            mode = FPUCS_TINY_EXC;
        end
    end
endmodule

// >>> rtl/fpucs_top.sv
/*
 * fpucs_top: float control and status register bank with APB access,
 * datapath update port and trap output.
 * Four further offsets read back narrower views of the same state.
 * Assumes APB master on pclk; datapath strobes are synchronous to pclk.
 * Assumes each datapath strobe stands for a single cycle.
 */
// Decided for this implementation: register access over APB and the address map.
// Overview of operation
// - eight condition bits at 31:25 and 23 are written by compares and read by branches.
// - flush bit 24 set makes denormal inputs zero and flushes tiny results per rounding.
// - flush bit clear makes a denormal input raise unimplemented operation.
// - override bit 22 keeps tiny intermediates unbounded, else flush and nearest bits decide.
// - nearest bit 21 rounds tiny results to zero or smallest normal under nearest mode.
// - bit 20 reads zero and multiply-add is unfused.
// - bit 19 reads one and abs/negate accept quiet NaN without trap.
// - bit 18 reads one and quiet NaN has leading fraction bit one.
// - cause field 17:12 reports the current instruction's exceptions.
// - enable field 11:7 holds one trap enable per IEEE condition.
// - a trap is taken when an enable and its cause are both set, or on any unimplemented operation.
// - sticky flags 6:2 accumulate until software clears them.
// - field 1:0 selects nearest, zero, plus or minus infinity rounding.
`timescale 1ns/1ns
module fpucs_top
    import fpucs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // datapath: compare result
    input wire logic cmp_valid,
    input wire logic [2:0] cmp_index,
    input wire logic cmp_result,
    // datapath: completed arithmetic instruction
    input wire logic op_done,
    input wire logic [4:0] op_ieee,
    input wire logic op_denormal_in,
    // controls seen by the datapath
    output logic [7:0] compare_condition_bits,
    output logic [1:0] rounding_select,
    output fpucs_tiny_t tiny_mode,
    output logic denormal_as_zero,
    output logic fused_madd_indicator,
    output logic abs_neg_format_indicator,
    output logic nan_encoding_indicator,
    // trap
    output logic fp_trap,
    output logic [4:0] fp_trap_src
);
    // =========================================
    // state
    logic [7:0] cc_r;
    logic fs_r;
    logic fo_r;
    logic fn_r;
    logic [5:0] cause_r;
    logic [4:0] en_r;
    logic [4:0] flag_r;
    logic [1:0] rm_r;
    logic [1:0] rm_nxt;
    logic [5:0] cause_nxt;
    fpucs_tiny_t tiny_w;

    // =========================================
    // bus decode
    function automatic logic hit_at(input logic [11:0] a, input logic [11:0] off);
        hit_at = (a == off);
    endfunction

    logic wr_en;
    logic rd_en;
    logic mapped;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign mapped = hit_at(paddr, FPUCS_CSR_OFF) | hit_at(paddr, FPUCS_CC_OFF)
        | hit_at(paddr, FPUCS_EXC_OFF) | hit_at(paddr, FPUCS_ENR_OFF)
        | hit_at(paddr, FPUCS_TRAP_OFF);

    logic w_csr;
    logic w_cc;
    logic w_exc;
    logic w_enr;
    assign w_csr = wr_en & hit_at(paddr, FPUCS_CSR_OFF);
    assign w_cc = wr_en & hit_at(paddr, FPUCS_CC_OFF);
    assign w_exc = wr_en & hit_at(paddr, FPUCS_EXC_OFF);
    assign w_enr = wr_en & hit_at(paddr, FPUCS_ENR_OFF);

    // read views selected at setup
    logic r_csr;
    logic r_cc;
    logic r_exc;
    logic r_enr;
    logic r_trap;
    assign r_csr = rd_en & hit_at(paddr, FPUCS_CSR_OFF);
    assign r_cc = rd_en & hit_at(paddr, FPUCS_CC_OFF);
    assign r_exc = rd_en & hit_at(paddr, FPUCS_EXC_OFF);
    assign r_enr = rd_en & hit_at(paddr, FPUCS_ENR_OFF);
    assign r_trap = rd_en & hit_at(paddr, FPUCS_TRAP_OFF);

    // full register image
    logic [31:0] csr_img;
    always_comb begin
        csr_img = FPUCS_ZERO;
        csr_img[FPUCS_CC_HI:FPUCS_CC_LO7] = cc_r[7:1];
        csr_img[FPUCS_FS_BIT] = fs_r;
        csr_img[FPUCS_CC0_BIT] = cc_r[0];
        csr_img[FPUCS_FO_BIT] = fo_r;
        csr_img[FPUCS_FN_BIT] = fn_r;
        csr_img[FPUCS_MAC_BIT] = FPUCS_MAC_VAL;
        csr_img[FPUCS_ABS_BIT] = FPUCS_ABS_VAL;
        csr_img[FPUCS_NAN_BIT] = FPUCS_NAN_VAL;
        csr_img[FPUCS_CAUSE_LO +: 6] = cause_r;
        csr_img[FPUCS_EN_LO +: 5] = en_r;
        csr_img[FPUCS_FLAG_LO +: 5] = flag_r;
        csr_img[FPUCS_RM_LO +: 2] = rm_r;
    end

    // alternate register views
    logic [31:0] cc_img;
    logic [31:0] exc_img;
    logic [31:0] enr_img;
    logic [31:0] trap_img;
    assign cc_img = {24'h000000, cc_r};
    assign exc_img = {14'h0000, cause_r, 5'h00, flag_r, 2'h0};
    assign enr_img = {20'h00000, en_r, 4'h0, fs_r, rm_r};
    assign trap_img = {26'h0000000, fp_trap_src, fp_trap};

    // =========================================
    // apb answer: no wait state, read data registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & ~penable;
        end
    end

    // unmapped addresses answer with an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel & ~penable & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= FPUCS_ZERO;
        end else if (rd_en) begin
            prdata <= FPUCS_ZERO;
            if (r_csr) begin
                prdata <= csr_img;
            end else if (r_cc) begin
                prdata <= cc_img;
            end else if (r_exc) begin
                prdata <= exc_img;
            end else if (r_enr) begin
                prdata <= enr_img;
            end else if (r_trap) begin
                prdata <= trap_img;
            end
        end
    end

    // writes take effect at the access edge where pready is high
    logic wr_go;
    assign wr_go = pready;

    // =========================================
    // condition codes: software write, compare has priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_r <= FPUCS_CC_RST;
        end else begin
            if (wr_go && w_csr) begin
                cc_r <= {pwdata[FPUCS_CC_HI:FPUCS_CC_LO7], pwdata[FPUCS_CC0_BIT]};
            end else if (wr_go && w_cc) begin
                cc_r <= pwdata[7:0];
            end
            if (cmp_valid) begin
                cc_r[cmp_index] <= cmp_result;
            end
        end
    end

    // =========================================
    // flush controls and rounding
    always_comb begin
        rm_nxt = rm_r;
        if (wr_go && w_csr) begin
            rm_nxt = pwdata[FPUCS_RM_LO +: 2];
        end else if (wr_go && w_enr) begin
            rm_nxt = pwdata[1:0];
        end
    end

    // flush-to-zero, also reachable through the enable view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs_r <= 1'b0;
        end else if (wr_go && w_csr) begin
            fs_r <= pwdata[FPUCS_FS_BIT];
        end else if (wr_go && w_enr) begin
            fs_r <= pwdata[2];
        end
    end

    // tiny-result controls; bits 20:18 have no storage, so writes drop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fo_r <= 1'b0;
        end else if (wr_go && w_csr) begin
            fo_r <= pwdata[FPUCS_FO_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fn_r <= 1'b0;
        end else if (wr_go && w_csr) begin
            fn_r <= pwdata[FPUCS_FN_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rm_r <= FPUCS_RM_RST;
        end else begin
            rm_r <= rm_nxt;
        end
    end

    // =========================================
    // trap trap_enable_field
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= FPUCS_EN_RST;
        end else if (wr_go && w_csr) begin
            en_r <= pwdata[FPUCS_EN_LO +: 5];
        end else if (wr_go && w_enr) begin
            en_r <= pwdata[11:7];
        end
    end

    // =========================================
    // cause: replaced by each completed op; denormal without flush -> unimpl
    always_comb begin
        cause_nxt = cause_r;
        if (wr_go && (w_csr || w_exc)) begin
            cause_nxt = pwdata[FPUCS_CAUSE_LO +: 6];
        end
        if (op_done) begin
            if (op_denormal_in && !fs_r) begin
                cause_nxt = 6'h20;
            end else begin
                cause_nxt = {1'b0, op_ieee};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= FPUCS_CAUSE_RST;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    // =========================================
    // sticky flags: set wins over a software clear in the same cycle
    logic [4:0] flag_set;
    assign flag_set = (op_done && !(op_denormal_in && !fs_r)) ? op_ieee : 5'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_r <= FPUCS_FLAG_RST;
        end else if (wr_go && (w_csr || w_exc)) begin
            flag_r <= pwdata[FPUCS_FLAG_LO +: 5] | flag_set;
        end else begin
            flag_r <= flag_r | flag_set;
        end
    end

    // =========================================
    // datapath controls, registered
    fpucs_tiny u_tiny (
        .flush_tiny_enable(fs_r),
        .flush_override(fo_r),
        .flush_nearest(fn_r),
        .rounding_select(rm_r),
        .mode(tiny_w)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_condition_bits <= FPUCS_CC_RST;
            rounding_select <= FPUCS_RM_RST;
            tiny_mode <= FPUCS_TINY_EXC;
            denormal_as_zero <= 1'b0;
        end else begin
            compare_condition_bits <= cc_r;
            rounding_select <= rm_r;
            tiny_mode <= tiny_w;
            denormal_as_zero <= fs_r;
        end
    end

    // hardwired indicators, kept in flops so every output is registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fused_madd_indicator <= FPUCS_MAC_VAL;
            abs_neg_format_indicator <= FPUCS_ABS_VAL;
            nan_encoding_indicator <= FPUCS_NAN_VAL;
        end else begin
            fused_madd_indicator <= FPUCS_MAC_VAL;
            abs_neg_format_indicator <= FPUCS_ABS_VAL;
            nan_encoding_indicator <= FPUCS_NAN_VAL;
        end
    end

    // =========================================
    // trap
    fpucs_trap u_trap (
        .pclk(pclk),
        .presetn(presetn),
        .cause(cause_r),
        .trap_enable_field(en_r),
        .trap(fp_trap),
        .trap_src(fp_trap_src)
    );
endmodule

// >>> rtl/fpucs_trap.sv
/*
 * fpucs_trap: compares cause bits with trap_enable_field and registers the trap.
 * Assumes cause/enable come from registers on the same clock.
 */
`timescale 1ns/1ns
module fpucs_trap
    import fpucs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // fields
    input wire logic [5:0] cause,
    input wire logic [4:0] trap_enable_field,
    // result
    output logic trap,
    output logic [4:0] trap_src
);
    // =========================================
    // match per IEEE condition; unimplemented op always traps
    logic [4:0] hit;
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_hit
            assign hit[g] = cause[g] & trap_enable_field[g];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap <= 1'b0;
            trap_src <= 5'h00;
        end else begin
            trap <= (|hit) | cause[5];
            trap_src <= hit;
        end
    end
endmodule

// >>> verif/fpu_control_status_test.sv
/*
 * fpu_control_status_test: self-checking bench for fpucs_top.
 * Assumes the datapath model and bound checker are compiled first.
 */
`timescale 1ns/1ns
module fpu_control_status_test;
    import fpucs_pkg::*;
    typedef struct packed {
        logic w;
        logic [11:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } fpucs_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, er, cmp_valid, cmp_result, op_done, op_denormal_in;
    logic [2:0] cmp_index;
    logic [4:0] op_ieee, fp_trap_src;
    logic [7:0] compare_condition_bits;
    logic [1:0] rounding_select;
    fpucs_tiny_t tiny_mode;
    logic denormal_as_zero, fused_madd_indicator, abs_neg_format_indicator;
    logic nan_encoding_indicator, fp_trap;
    int n_fail = 0;
    int cmp_count = 0;
    fpucs_row_t rows[8] = '{
        '{1'b1, 12'h000, 32'hFFFF_FFFF, 32'hFFEF_FFFF, 1'b0},
        '{1'b1, 12'h000, 32'h0, 32'h000C_0000, 1'b0},
        '{1'b1, 12'h004, 32'hFFFF_FFFF, 32'h0000_00FF, 1'b0},
        '{1'b1, 12'h008, 32'hFFFF_FFFF, 32'h0003_F07C, 1'b0},
        '{1'b1, 12'h00C, 32'hFFFF_FFFF, 32'h0000_0F87, 1'b0},
        '{1'b1, 12'h014, 32'hFFFF_FFFF, 32'h0, 1'b1},
        '{1'b0, 12'h010, 32'h0, 32'h0000_003F, 1'b0},
        '{1'b0, 12'h000, 32'h0, 32'hFF8F_FFFF, 1'b0}};
    logic [31:0] tv[5] = '{32'h0040_0000, 32'h0020_0000, 32'h0020_0001, 32'h0100_0000, 32'h0};
    fpucs_tiny_t tm[5] = '{FPUCS_TINY_KEEP, FPUCS_TINY_NEAR, FPUCS_TINY_FLUSH,
        FPUCS_TINY_FLUSH, FPUCS_TINY_EXC};

    fpucs_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .cmp_valid, .cmp_index, .cmp_result, .op_done, .op_ieee,
        .op_denormal_in, .compare_condition_bits, .rounding_select, .tiny_mode,
        .denormal_as_zero, .fused_madd_indicator, .abs_neg_format_indicator,
        .nan_encoding_indicator, .fp_trap, .fp_trap_src);
    fpucs_dp_model i_dp (.pclk, .cmp_valid, .cmp_index, .cmp_result, .op_done, .op_ieee,
        .op_denormal_in);

    always #4 pclk = ~pclk;
    // =========================================
    // tasks
    task automatic end_sim;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        cmp_count++;
        if (s !== x) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // left in access until next setup or idle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk({31'h0, pready}, 32'h1);
            end_sim;
        end
        rv = prdata;
        er = pslverr;
    endtask
    task automatic idle;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        idle;
    endtask
    task automatic rdx(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        idle;
        chk(rv, x);
    endtask
    // =========================================
    // main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdx(FPUCS_CSR_OFF, 32'h000C_0000);
        chk({28'h0, tiny_mode}, {28'h0, FPUCS_TINY_EXC});
        foreach (rows[i]) begin
            if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
            apb(1'b0, rows[i].a, 32'h0);
            chk(rv, rows[i].x);
            chk({31'h0, er}, {31'h0, rows[i].e});
        end
        idle;
        for (int m = 0; m < 4; m++) begin
            wr(FPUCS_ENR_OFF, 32'(m));
            cyc(2);
            chk({30'h0, rounding_select}, 32'(m));
        end
        wr(FPUCS_ENR_OFF, 32'h4);
        wr(FPUCS_EXC_OFF, 32'h0);
        i_dp.op(5'h11, 1'b0);
        i_dp.op(5'h04, 1'b0);
        rdx(FPUCS_EXC_OFF, 32'h0000_4054);
        chk({31'h0, fp_trap}, 32'h0);
        wr(FPUCS_ENR_OFF, 32'h204);
        cyc(2);
        chk({26'h0, fp_trap_src, fp_trap}, 32'h9);
        wr(FPUCS_EXC_OFF, 32'h1000);
        cyc(2);
        chk({31'h0, fp_trap}, 32'h0);
        wr(FPUCS_ENR_OFF, 32'h84);
        cyc(2);
        chk({26'h0, fp_trap_src, fp_trap}, 32'h3);
        wr(FPUCS_ENR_OFF, 32'h0);
        wr(FPUCS_EXC_OFF, 32'h0);
        i_dp.op(5'h00, 1'b1);
        cyc(2);
        rdx(FPUCS_EXC_OFF, 32'h0002_0000);
        chk({31'h0, fp_trap}, 32'h1);
        wr(FPUCS_ENR_OFF, 32'h4);
        wr(FPUCS_EXC_OFF, 32'h0);
        cyc(2);
        chk({31'h0, denormal_as_zero}, 32'h1);
        i_dp.op(5'h01, 1'b1);
        cyc(2);
        rdx(FPUCS_EXC_OFF, 32'h0000_1004);
        for (int i = 0; i < 5; i++) begin
            wr(FPUCS_CSR_OFF, tv[i]);
            cyc(2);
            chk({28'h0, tiny_mode}, {28'h0, tm[i]});
        end
        wr(FPUCS_CC_OFF, 32'h0);
        i_dp.cmp(3'h3, 1'b1);
        cyc(2);
        rdx(FPUCS_CC_OFF, 32'h0000_0008);
        chk({24'h0, compare_condition_bits}, 32'h8);
        // mid-run reset with every field set
        wr(FPUCS_CSR_OFF, 32'hFFFF_FFFF);
        cyc(2);
        chk({31'h0, fp_trap}, 32'h1);
        presetn <= 1'b0;
        cyc(2);
        chk({26'h0, fp_trap_src, fp_trap}, 32'h0);
        chk({24'h0, compare_condition_bits}, 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        rdx(FPUCS_CSR_OFF, 32'h000C_0000);
        chk({28'h0, tiny_mode}, {28'h0, FPUCS_TINY_EXC});
        end_sim;
    end
endmodule

// >>> verif/fpucs_dp_model.sv
/*
 * fpucs_dp_model: arithmetic datapath stand-in driving compare and op strobes.
 * Assumes tasks are called just after a rising pclk edge.
 */
`timescale 1ns/1ns
module fpucs_dp_model (
    // clock
    input wire logic pclk,
    // strobes to the register bank
    output logic cmp_valid,
    output logic [2:0] cmp_index,
    output logic cmp_result,
    output logic op_done,
    output logic [4:0] op_ieee,
    output logic op_denormal_in
);
    initial begin
        cmp_valid = 1'b0;
        cmp_index = 3'h0;
        cmp_result = 1'b0;
        op_done = 1'b0;
        op_ieee = 5'h0;
        op_denormal_in = 1'b0;
    end
    // =========================================
    // one-cycle strobes; qualifiers flip once released
    task automatic cmp(input logic [2:0] i, input logic r);
        cmp_valid <= 1'b1;
        cmp_index <= i;
        cmp_result <= r;
        @(posedge pclk);
        cmp_valid <= 1'b0;
        cmp_index <= ~i;
        cmp_result <= ~r;
        @(posedge pclk);
    endtask
    task automatic op(input logic [4:0] f, input logic dn);
        op_done <= 1'b1;
        op_ieee <= f;
        op_denormal_in <= dn;
        @(posedge pclk);
        op_done <= 1'b0;
        op_ieee <= ~f;
        op_denormal_in <= ~dn;
        @(posedge pclk);
    endtask
endmodule

// >>> verif/fpucs_top_asserts.sv
/*
 * fpucs_top_chk: port-level properties of the float control/status bank.
 * Assumes binding to fpucs_top; one clock, async active-low reset.
 */
`timescale 1ns/1ns
module fpucs_top_chk
    import fpucs_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // datapath
    input wire logic cmp_valid,
    input wire logic [2:0] cmp_index,
    input wire logic cmp_result,
    input wire logic op_done,
    input wire logic op_denormal_in,
    // controls and trap
    input wire logic [7:0] compare_condition_bits,
    input wire logic [1:0] rounding_select,
    input wire fpucs_tiny_t tiny_mode,
    input wire logic denormal_as_zero,
    input wire logic fused_madd_indicator,
    input wire logic abs_neg_format_indicator,
    input wire logic nan_encoding_indicator,
    input wire logic fp_trap,
    input wire logic [4:0] fp_trap_src
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [31:0] wd_r;
    logic [2:0] ci_r;
    logic cr_r;
    // =========================================
    // last written word and last compare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_r <= '0;
        end else if (psel && penable && pready && pwrite) begin
            wd_r <= pwdata;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ci_r <= 3'h0;
            cr_r <= 1'b0;
        end else if (cmp_valid) begin
            ci_r <= cmp_index;
            cr_r <= cmp_result;
        end
    end
    // =========================================
    // properties
    sequence s_enr_wr;
        psel && penable && pready && pwrite && paddr == FPUCS_ENR_OFF;
    endsequence
    sequence s_den_op;
        op_done && op_denormal_in && !denormal_as_zero;
    endsequence
    property p_rm;
        s_enr_wr |-> ##[1:2] rounding_select == wd_r[1:0];
    endproperty
    property p_daz;
        s_enr_wr |-> ##[1:2] denormal_as_zero == wd_r[2];
    endproperty
    property p_cmp;
        cmp_valid |-> ##[1:2] compare_condition_bits[ci_r] == cr_r;
    endproperty
    property p_ind;
        {fused_madd_indicator, abs_neg_format_indicator, nan_encoding_indicator}
            == {FPUCS_MAC_VAL, FPUCS_ABS_VAL, FPUCS_NAN_VAL};
    endproperty
    property p_hot;
        $onehot(tiny_mode);
    endproperty
    property p_exc;
        tiny_mode == FPUCS_TINY_EXC |-> !denormal_as_zero;
    endproperty
    property p_near;
        tiny_mode == FPUCS_TINY_NEAR |-> rounding_select == FPUCS_RM_NEAREST;
    endproperty
    property p_den;
        s_den_op |-> ##[1:2] fp_trap;
    endproperty
    property p_src;
        fp_trap_src != 5'h0 |-> fp_trap;
    endproperty
    a_rm: assert property (p_rm) else $error("rounding output missed write");
    a_daz: assert property (p_daz) else $error("flush output missed write");
    a_cmp: assert property (p_cmp) else $error("condition bit not updated");
    a_ind: assert property (p_ind) else $error("indicator bits wrong");
    a_hot: assert property (p_hot) else $error("tiny mode not one-hot");
    a_exc: assert property (p_exc) else $error("denormal mode with flush on");
    a_near: assert property (p_near) else $error("nearest flush off nearest");
    a_den: assert property (p_den) else $error("denormal op gave no trap");
    a_src: assert property (p_src) else $error("trap source without trap");
endmodule

bind fpucs_top fpucs_top_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .cmp_valid, .cmp_index, .cmp_result, .op_done, .op_denormal_in,
    .compare_condition_bits, .rounding_select, .tiny_mode, .denormal_as_zero,
    .fused_madd_indicator, .abs_neg_format_indicator, .nan_encoding_indicator,
    .fp_trap, .fp_trap_src);
